// ---- rtl/wdt_pwr_ctrl.sv ----
// watchdog, power management and reset supervisor
// Operation
// - watchdog counts only while the enable bit is set; disabled means no time-out
// - writing clear bit zeroes counter, prescaler and the bit on the next machine cycle
// - run-in-idle bit keeps the watchdog counting in idle; cleared it stops it
// - prescale select 000..111 gives 2,8,4,16,32,64,128,256 as mapped
// - time-out equals oscillator period times 12 times 2^14 times prescaler
// - enabled watchdog time-out causes a full system reset
// - any reset disables the watchdog and clears counter and prescaler
// - idle bit stops the core clock; peripherals and interrupts keep running
// - idle is left on any enabled interrupt or on reset
// - power-down stops all clocks; only a reset leaves it, never an interrupt
// - power-on flag set on power-on, cleared only by software, kept across resets
// - two user flags are plain read/write storage
// - reset pin sampled once per machine cycle; needs two consecutive high samples
// - short glitches on the reset pin do not reset the device
// - on reset power_control clears except the power-on flag; other registers clear (irq status, irq mask and reset cause clear on rst_in only)
// - oscillator is divided by two before internal use
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`include "wdt_pwr_regs.svh"

module wdt_pwr_ctrl
   import wdt_pwr_pkg::*;
(
   // clock and power-on reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // system
   input wire logic ext_reset_in,
   input wire logic irq_pending_in,
   output logic sys_reset_out,
   output logic core_clk_en_out,
   output logic periph_clk_en_out,
   output logic half_clk_en_out,
   output logic machine_tick_out,
   output logic irq_out
);

   // ***************************************
   // helpers
   // ***************************************
   // prescaler ratio as log2; codes 001 and 010 are swapped in the encoding
   function automatic logic [3:0] ps_log2(input logic [2:0] sel);
      case (sel)
         3'h0: ps_log2 = 4'h1;
         3'h2: ps_log2 = 4'h2;
         3'h1: ps_log2 = 4'h3;
         3'h3: ps_log2 = 4'h4;
         3'h4: ps_log2 = 4'h5;
         3'h5: ps_log2 = 4'h6;
         3'h6: ps_log2 = 4'h7;
         default: ps_log2 = 4'h8;
      endcase
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // ***************************************
   // clocking: half rate and machine cycle
   // ***************************************
   logic half_r;
   logic [3:0] osc_cnt_r;
   logic machine_tick;
   logic sample_tick;
   logic pd_stopped;

   assign machine_tick = (osc_cnt_r == 4'(`OSC_PER_MACHINE - 1)) && !pd_stopped;
   assign sample_tick = (osc_cnt_r == 4'(`MACHINE_STATE_SAMPLE)) && !pd_stopped;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         half_r <= 1'b0;
         osc_cnt_r <= 4'h0;
      end else if (!pd_stopped) begin
         half_r <= ~half_r;
         if (osc_cnt_r == 4'(`OSC_PER_MACHINE - 1)) begin
            osc_cnt_r <= 4'h0;
         end else begin
            osc_cnt_r <= osc_cnt_r + 4'h1;
         end
      end
   end

   // ***************************************
   // external reset filter
   // ***************************************
   // a pin high on one sample only is taken as a glitch
   logic [1:0] rst_hist_r;
   logic ext_reset_hit;

   assign ext_reset_hit = sample_tick && ext_reset_in && (rst_hist_r[0] == 1'b1);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rst_hist_r <= 2'h0;
      end else if (sample_tick) begin
         rst_hist_r <= {rst_hist_r[0], ext_reset_in};
      end
   end

   // ***************************************
   // system reset pulse
   // ***************************************
   logic wd_timeout;
   logic [2:0] sysrst_cnt_r;
   logic sys_reset_r;
   logic soft_reset;

   // the pulse outlives its cause so every register on soft_reset sees at least one reset edge
   assign soft_reset = sys_reset_r;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sysrst_cnt_r <= 3'h0;
         sys_reset_r <= 1'b1;
      end else if (wd_timeout || ext_reset_hit) begin
         sysrst_cnt_r <= 3'(`SYS_RESET_CYCLES);
         sys_reset_r <= 1'b1;
      end else if (sysrst_cnt_r != 3'h0) begin
         sysrst_cnt_r <= sysrst_cnt_r - 3'h1;
         sys_reset_r <= 1'b1;
      end else begin
         sys_reset_r <= 1'b0;
      end
   end

   // ***************************************
   // watchdog_control register
   // ***************************************
   logic wd_en_r;
   logic wd_clear_r;
   logic wd_idle_run_r;
   logic [2:0] wd_ps_r;
   logic wr_wdc;

   assign wr_wdc = wr_in && hit(addr_in, `OFS_WATCHDOG_CONTROL);

   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_reset) begin
         wd_en_r <= 1'b0;
         wd_idle_run_r <= 1'b0;
         wd_ps_r <= 3'h0;
      end else if (wr_wdc) begin
         wd_en_r <= wdata_in[`WC_ENABLE];
         wd_idle_run_r <= wdata_in[`WC_RUN_IDLE];
         wd_ps_r <= wdata_in[`WC_PS_HI:`WC_PS_LO];
      end
   end

   // clear bit holds until the next machine cycle boundary, then self-clears
   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_reset) begin
         wd_clear_r <= 1'b0;
      end else if (wr_wdc && wdata_in[`WC_CLEAR]) begin
         wd_clear_r <= 1'b1;
      end else if (machine_tick) begin
         wd_clear_r <= 1'b0;
      end
   end

   // ***************************************
   // power_control register and mode
   // ***************************************
   logic idle_r;
   logic pd_r;
   logic uf0_r;
   logic uf1_r;
   logic pof_r;
   pm_state_e pm_r;
   logic wr_pc;

   assign wr_pc = wr_in && hit(addr_in, `OFS_POWER_CONTROL);
   // power-down freezes the dividers as well, so the pin sampler is dead there too
   assign pd_stopped = (pm_r == pm_power_down);

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         pof_r <= 1'b1;
      end else if (wr_pc && !wdata_in[`PC_POWER_ON]) begin
         pof_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_reset) begin
         uf0_r <= 1'b0;
         uf1_r <= 1'b0;
      end else if (wr_pc) begin
         uf0_r <= wdata_in[`PC_USER_FLAG_0];
         uf1_r <= wdata_in[`PC_USER_FLAG_1];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_reset) begin
         pm_r <= pm_run;
         idle_r <= 1'b0;
         pd_r <= 1'b0;
      end else begin
         case (pm_r)
            pm_run: begin
               if (wr_pc && wdata_in[`PC_POWER_DOWN]) begin
                  pm_r <= pm_power_down;
                  pd_r <= 1'b1;
               end else if (wr_pc && wdata_in[`PC_IDLE]) begin
                  pm_r <= pm_idle;
                  idle_r <= 1'b1;
               end
            end
            pm_idle: begin
               if (irq_pending_in) begin
                  pm_r <= pm_run;
                  idle_r <= 1'b0;
               end
            end
            default: begin
               pm_r <= pm_power_down;
            end
         endcase
      end
   end

   // ***************************************
   // watchdog counter
   // ***************************************
   logic [7:0] pre_r;
   logic [13:0] wd_cnt_r;
   logic pre_done;
   logic wd_run;

   // idle only stops the count; a pending clear still lands on the next tick
   assign wd_run = wd_en_r && !pd_stopped && (pm_r != pm_idle || wd_idle_run_r);
   assign pre_done = (pre_r == 8'((9'h001 << ps_log2(wd_ps_r)) - 9'h001));
   assign wd_timeout = wd_run && machine_tick && pre_done && (wd_cnt_r == 14'h3FFF);

   always_ff @(posedge mclk_in) begin
      if (rst_in || soft_reset || (wd_clear_r && machine_tick)) begin
         pre_r <= 8'h00;
         wd_cnt_r <= 14'h0000;
      end else if (wd_run && machine_tick) begin
         if (pre_done) begin
            pre_r <= 8'h00;
            wd_cnt_r <= wd_cnt_r + 14'h0001;
         end else begin
            pre_r <= pre_r + 8'h01;
         end
      end
   end

   // ***************************************
   // interrupts: sticky status, mask
   // ***************************************
   logic [`IRQ_BITS-1:0] irq_stat_r;
   logic [`IRQ_BITS-1:0] irq_mask_r;
   logic [`IRQ_BITS-1:0] irq_set;
   logic [`IRQ_BITS-1:0] irq_clr;

   assign irq_set = {(pm_r == pm_idle) && irq_pending_in, ext_reset_hit, wd_timeout};
   assign irq_clr = (wr_in && hit(addr_in, `OFS_IRQ_STATUS)) ? wdata_in[`IRQ_BITS-1:0] : '0;

   // status survives system reset so software can see what caused it
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         irq_mask_r <= '0;
      end else if (wr_in && hit(addr_in, `OFS_IRQ_MASK)) begin
         irq_mask_r <= wdata_in[`IRQ_BITS-1:0];
      end
   end

   // ***************************************
   // read port and outputs
   // ***************************************
   byte_t rd_val;

   always_comb begin
      rd_val = 8'h00;
      if (hit(addr_in, `OFS_POWER_CONTROL)) begin
         rd_val = {3'h0, pof_r, uf1_r, uf0_r, pd_r, idle_r};
      end else if (hit(addr_in, `OFS_WATCHDOG_CONTROL)) begin
         rd_val = {wd_en_r, wd_clear_r, wd_idle_run_r, 2'h0, wd_ps_r};
      end else if (hit(addr_in, `OFS_IRQ_STATUS)) begin
         rd_val = {5'h00, irq_stat_r};
      end else if (hit(addr_in, `OFS_IRQ_MASK)) begin
         rd_val = {5'h00, irq_mask_r};
      end else if (hit(addr_in, `OFS_RESET_CAUSE)) begin
         rd_val = {6'h00, rst_hist_r};
      end
   end

   // zero outside the answer cycle, so a late sample never reads stale data
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_out <= 8'h00;
      end else if (rd_in) begin
         rdata_out <= rd_val;
      end else begin
         rdata_out <= 8'h00;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         sys_reset_out <= 1'b1;
         core_clk_en_out <= 1'b0;
         periph_clk_en_out <= 1'b0;
         half_clk_en_out <= 1'b0;
         machine_tick_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         sys_reset_out <= sys_reset_r || wd_timeout || ext_reset_hit;
         core_clk_en_out <= (pm_r == pm_run) && half_r;
         periph_clk_en_out <= !pd_stopped && half_r;
         half_clk_en_out <= half_r && !pd_stopped;
         machine_tick_out <= machine_tick;
         irq_out <= |((irq_stat_r | irq_set) & irq_mask_r);
      end
   end

   // ***************************************
   // checks
   // ***************************************
   a_wd_disabled_quiet: assert property (@(posedge mclk_in) disable iff (rst_in)
      !wd_en_r |-> !wd_timeout) else $error("time-out while disabled");
   a_clear_self_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
      wd_clear_r && machine_tick && !wr_wdc |=> !wd_clear_r && wd_cnt_r == 14'h0000)
      else $error("clear bit did not clear");
   a_idle_stops_wd: assert property (@(posedge mclk_in) disable iff (rst_in)
      pm_r == pm_idle && !wd_idle_run_r && !wd_clear_r && !soft_reset |=> $stable(wd_cnt_r))
      else $error("watchdog ran in idle");
   a_ps_ratio_two: assert property (@(posedge mclk_in) disable iff (rst_in)
      wd_ps_r == 3'h0 && pre_r == 8'h01 |-> pre_done) else $error("ratio 2 wrong");
   a_timeout_resets: assert property (@(posedge mclk_in) disable iff (rst_in)
      wd_timeout |=> sys_reset_out ##1 sys_reset_r) else $error("no reset");
   a_reset_disables: assert property (@(posedge mclk_in) disable iff (rst_in)
      soft_reset |=> !wd_en_r && pre_r == 8'h00) else $error("wd alive in reset");
   a_idle_core_off: assert property (@(posedge mclk_in) disable iff (rst_in)
      pm_r == pm_idle |=> !core_clk_en_out) else $error("core clocked in idle");
   a_pd_no_wake: assert property (@(posedge mclk_in) disable iff (rst_in)
      pm_r == pm_power_down && !soft_reset |=> pm_r == pm_power_down)
      else $error("left power-down");
   a_pof_kept: assert property (@(posedge mclk_in) disable iff (rst_in)
      !wr_pc |=> $stable(pof_r)) else $error("power-on flag moved");
   a_reset_two_samples: assert property (@(posedge mclk_in) disable iff (rst_in)
      ext_reset_hit |-> $past(ext_reset_in, 12)) else $error("single sample reset");
   a_idle_wake: assert property (@(posedge mclk_in) disable iff (rst_in)
      pm_r == pm_idle && irq_pending_in && !soft_reset |=> pm_r == pm_run)
      else $error("no wake");
   a_pd_clocks_off: assert property (@(posedge mclk_in) disable iff (rst_in)
      pd_stopped |=> !periph_clk_en_out && !core_clk_en_out) else $error("clock in power-down");
   a_cnt_step: assert property (@(posedge mclk_in) disable iff (rst_in)
      wd_run && machine_tick && pre_done && !wd_clear_r && !soft_reset
      |=> wd_cnt_r == $past(wd_cnt_r) + 14'h0001) else $error("count step wrong");
   a_irq_level: assert property (@(posedge mclk_in) disable iff (rst_in)
      |(irq_stat_r & irq_mask_r) |=> irq_out) else $error("irq not raised");

endmodule

// ---- rtl/wdt_pwr_regs.svh ----
// register offsets, field positions, reset values and timing counts for the supervisor
`ifndef WDT_PWR_REGS_SVH
`define WDT_PWR_REGS_SVH

// ***************************************
// register offsets
// ***************************************
`define OFS_POWER_CONTROL 8'h87
`define OFS_WATCHDOG_CONTROL 8'h8F
`define OFS_IRQ_STATUS 8'h90
`define OFS_IRQ_MASK 8'h91
`define OFS_RESET_CAUSE 8'h92

// ***************************************
// power_control fields
// ***************************************
`define PC_IDLE 0
`define PC_POWER_DOWN 1
`define PC_USER_FLAG_0 2
`define PC_USER_FLAG_1 3
`define PC_POWER_ON 4

// ***************************************
// watchdog_control fields
// ***************************************
`define WC_ENABLE 7
`define WC_CLEAR 6
`define WC_RUN_IDLE 5
`define WC_PS_HI 2
`define WC_PS_LO 0
`define WC_RESET 8'h00

// ***************************************
// interrupt status fields
// ***************************************
`define IRQ_WD_TIMEOUT 0
`define IRQ_EXT_RESET 1
`define IRQ_WAKE 2
`define IRQ_BITS 3

// ***************************************
// timing
// ***************************************
`define OSC_PER_MACHINE 12
`define MACHINE_STATE_SAMPLE 9
`define RESET_HOLD_MACHINES 2
`define WD_COUNT_BITS 14
`define SYS_RESET_CYCLES 4

`endif

// ---- rtl/wdt_pwr_pkg.sv ----
// types shared by the supervisor block
package wdt_pwr_pkg;
   typedef enum logic [1:0] {
      pm_run,
      pm_idle,
      pm_power_down
   } pm_state_e;
   typedef logic [7:0] byte_t;
endpackage

// ---- testbench/tb_top.sv ----
// self-checking bench for the watchdog, power and reset supervisor
`timescale 1ns/10ps
`include "wdt_pwr_regs.svh"

module tb_top
   import wdt_pwr_pkg::*;
();
   // ***************************************
   // stimulus and observed signals
   // ***************************************
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   byte_t addr_in = 8'h00;
   byte_t wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   byte_t rdata_out;
   logic ext_reset_in = 1'b0;
   logic irq_pending_in = 1'b0;
   logic sys_reset_out;
   logic core_clk_en_out;
   logic periph_clk_en_out;
   logic half_clk_en_out;
   logic machine_tick_out;
   logic irq_out;
   int err_total = 0;
   int checked = 0;

   wdt_pwr_ctrl dut_u (
      .mclk_in(mclk_in),
      .rst_in(rst_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .ext_reset_in(ext_reset_in),
      .irq_pending_in(irq_pending_in),
      .sys_reset_out(sys_reset_out),
      .core_clk_en_out(core_clk_en_out),
      .periph_clk_en_out(periph_clk_en_out),
      .half_clk_en_out(half_clk_en_out),
      .machine_tick_out(machine_tick_out),
      .irq_out(irq_out)
   );

   initial begin
      forever #5 mclk_in = ~mclk_in;
   end

   // ***************************************
   // shared tasks
   // ***************************************
   task automatic chk8(input string what, input byte_t exp, input byte_t got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic reg_wr(input byte_t a, input byte_t d);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input byte_t a, input byte_t exp);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      #1;
      chk8(what, exp, rdata_out);
   endtask

   task automatic count_en(input int n, output int core, output int per, output int half,
                           output int tick);
      core = 0;
      per = 0;
      half = 0;
      tick = 0;
      repeat (n) begin
         @(posedge mclk_in);
         #1;
         core += int'(core_clk_en_out === 1'b1);
         per += int'(periph_clk_en_out === 1'b1);
         half += int'(half_clk_en_out === 1'b1);
         tick += int'(machine_tick_out === 1'b1);
      end
   endtask

   // internal reset ends one cycle before the output falls, writes while it lasts are lost
   task automatic wait_calm();
      int n;
      n = 0;
      while (sys_reset_out !== 1'b0 && n < 100) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      chk1("reset release", 1'b0, sys_reset_out);
      repeat (8) @(posedge mclk_in);
   endtask

   task automatic stop_test();
      $display("checks %0d, errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_reset_values();
      rd_chk("power_control", `OFS_POWER_CONTROL, 8'h10);
      rd_chk("watchdog_control", `OFS_WATCHDOG_CONTROL, `WC_RESET);
      reg_wr(8'hA0, 8'hFF);
      rd_chk("unmapped", 8'hA0, 8'h00);
   endtask

   task automatic t_clocks();
      int c, p, h, t;
      count_en(120, c, p, h, t);
      chk8("half enables", 8'h3C, byte_t'(h));
      chk8("machine ticks", 8'h0A, byte_t'(t));
      chk8("core enables", 8'h3C, byte_t'(c));
   endtask

   task automatic t_user_flags();
      reg_wr(`OFS_POWER_CONTROL, 8'h1C);
      rd_chk("user flags", `OFS_POWER_CONTROL, 8'h1C);
      reg_wr(`OFS_POWER_CONTROL, 8'h00);
      rd_chk("flag cleared", `OFS_POWER_CONTROL, 8'h00);
      reg_wr(`OFS_POWER_CONTROL, 8'h10);
      rd_chk("flag not set by write", `OFS_POWER_CONTROL, 8'h00);
   endtask

   task automatic t_watchdog();
      for (int i = 0; i < 8; i++) begin
         reg_wr(`OFS_WATCHDOG_CONTROL, 8'h80 | byte_t'(i));
         rd_chk("prescale code", `OFS_WATCHDOG_CONTROL, 8'h80 | byte_t'(i));
      end
      reg_wr(`OFS_WATCHDOG_CONTROL, 8'hE3);
      repeat (14) @(posedge mclk_in);
      rd_chk("clear bit self clears", `OFS_WATCHDOG_CONTROL, 8'hA3);
   endtask

   task automatic t_pin_reset();
      int n;
      // one machine cycle high can meet only one sample
      ext_reset_in <= 1'b1;
      repeat (12) @(posedge mclk_in);
      ext_reset_in <= 1'b0;
      n = 0;
      repeat (36) begin
         @(posedge mclk_in);
         #1;
         n += int'(sys_reset_out !== 1'b0);
      end
      chk8("glitch resets", 8'h00, byte_t'(n));
      @(posedge mclk_in);
      ext_reset_in <= 1'b1;
      n = 0;
      while (sys_reset_out !== 1'b1 && n < 40) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      chk1("pin reset", 1'b1, sys_reset_out);
      ext_reset_in <= 1'b0;
      wait_calm();
      rd_chk("watchdog after reset", `OFS_WATCHDOG_CONTROL, 8'h00);
      rd_chk("flag kept", `OFS_POWER_CONTROL, 8'h00);
      rd_chk("pin event", `OFS_IRQ_STATUS, 8'h02);
      chk1("masked irq", 1'b0, irq_out);
   endtask

   task automatic t_idle_irq();
      int c, p, h, t;
      reg_wr(`OFS_POWER_CONTROL, 8'h01);
      repeat (4) @(posedge mclk_in);
      count_en(24, c, p, h, t);
      chk8("core in idle", 8'h00, byte_t'(c));
      chk8("periph in idle", 8'h0C, byte_t'(p));
      irq_pending_in <= 1'b1;
      count_en(12, c, p, h, t);
      chk1("idle wake", 1'b1, c > 0);
      irq_pending_in <= 1'b0;
      rd_chk("wake event", `OFS_IRQ_STATUS, 8'h06);
      reg_wr(`OFS_IRQ_MASK, 8'h04);
      repeat (2) @(posedge mclk_in);
      #1;
      chk1("unmasked irq", 1'b1, irq_out);
      reg_wr(`OFS_IRQ_STATUS, 8'h04);
      repeat (2) @(posedge mclk_in);
      #1;
      chk1("irq after clear", 1'b0, irq_out);
      reg_wr(`OFS_IRQ_STATUS, 8'h02);
      rd_chk("status cleared", `OFS_IRQ_STATUS, 8'h00);
   endtask

   // in 48*ratio clocks exactly four counter steps fall, whatever the start phase
   task automatic t_wd_rate(input byte_t code, input int ratio);
      logic [13:0] c0;
      logic [13:0] c1;
      reg_wr(`OFS_WATCHDOG_CONTROL, 8'hC0 | code);
      repeat (14) @(posedge mclk_in);
      #1;
      chk8("count after clear", 8'h00, byte_t'(dut_u.wd_cnt_r));
      c0 = dut_u.wd_cnt_r;
      repeat (48 * ratio) @(posedge mclk_in);
      #1;
      c1 = dut_u.wd_cnt_r;
      chk8("count rate", 8'h04, byte_t'(c1 - c0));
   endtask

   // ratio 2: eight machine cycles of idle give four steps when run-in-idle is set
   task automatic t_wd_idle(input byte_t run_bit, input byte_t exp);
      logic [13:0] c0;
      reg_wr(`OFS_WATCHDOG_CONTROL, 8'hC0 | run_bit);
      repeat (14) @(posedge mclk_in);
      reg_wr(`OFS_POWER_CONTROL, 8'h01);
      #1;
      c0 = dut_u.wd_cnt_r;
      repeat (96) @(posedge mclk_in);
      #1;
      chk8("count in idle", exp, byte_t'(dut_u.wd_cnt_r - c0));
      @(posedge mclk_in);
      irq_pending_in <= 1'b1;
      @(posedge mclk_in);
      irq_pending_in <= 1'b0;
      rd_chk("idle left", `OFS_POWER_CONTROL, 8'h00);
   endtask

   task automatic t_power_down();
      int c, p, h, t;
      reg_wr(`OFS_POWER_CONTROL, 8'h02);
      repeat (4) @(posedge mclk_in);
      irq_pending_in <= 1'b1;
      count_en(30, c, p, h, t);
      chk8("periph in power-down", 8'h00, byte_t'(p));
      chk8("core in power-down", 8'h00, byte_t'(c));
      irq_pending_in <= 1'b0;
      rst_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      rst_in <= 1'b0;
      wait_calm();
      count_en(24, c, p, h, t);
      chk8("periph after reset", 8'h0C, byte_t'(p));
      rd_chk("power-on flag", `OFS_POWER_CONTROL, 8'h10);
   endtask

   // ***************************************
   // main sequence and watchdog
   // ***************************************
   initial begin
      repeat (4) @(posedge mclk_in);
      rst_in <= 1'b0;
      wait_calm();
      t_reset_values();
      t_clocks();
      t_user_flags();
      t_watchdog();
      t_pin_reset();
      t_idle_irq();
      t_wd_rate(8'h00, 2);
      t_wd_rate(8'h02, 4);
      t_wd_rate(8'h01, 8);
      t_wd_idle(8'h00, 8'h00);
      t_wd_idle(8'h20, 8'h04);
      t_power_down();
      stop_test();
   end

   // the sequence needs about 1400 cycles
   initial begin
      #100000;
      err_total++;
      stop_test();
   end
endmodule
